// ==== verilog/dgp_pkg.sv ====
package dgp_pkg;
  // ****************************************************************
  // register indices (word aligned: printed offset is index, byte address is index times 4)
  // ****************************************************************
  localparam logic [7:0] IDX_TRIM_A   = 8'h1A;
  localparam logic [7:0] IDX_SPEED    = 8'h1B;
  localparam logic [7:0] IDX_WDKEY    = 8'h1C;
  localparam logic [7:0] IDX_START    = 8'h1D;
  localparam logic [7:0] IDX_IRQTRIG  = 8'h1E;
  localparam logic [7:0] IDX_PULSE0   = 8'h1F;
  localparam logic [7:0] IDX_PULSE1   = 8'h20;
  localparam logic [7:0] IDX_GPIO     = 8'h21;
  localparam logic [7:0] IDX_BANDGAP  = 8'h22;
  localparam logic [7:0] IDX_STATUS   = 8'h23;
  localparam int         ADDR_W       = 8;
  localparam int         IDX_LSB      = 2;
  // ****************************************************************
  // reset values and keys
  // ****************************************************************
  localparam logic [7:0] RST_TRIM_A   = 8'h52;
  localparam logic [7:0] RST_BANDGAP  = 8'h07;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_SPEED    = 8'h08;
  localparam logic [7:0] RST_TRIG     = 8'h02;
  localparam logic [7:0] WD_OFF_KEY   = 8'h5A;
  localparam logic [1:0] MONOFLOP_ON  = 2'h3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_HZ         = 64'd10000000;
  localparam longint WD_MIN_S       = 64'd9;
  localparam longint WD_TIMEOUT_S   = 64'd12;
  localparam longint WD_CYCLES      = WD_TIMEOUT_S * CLK_HZ;
  localparam int     WD_W           = 28;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MONO_HI = 7;
  localparam int MONO_LO = 6;
  localparam int SPD_HI  = 3;
  localparam int SPD_LO  = 2;
  localparam int SWAP_HI = 1;
  localparam int SWAP_LO = 0;
  localparam int NIB_HI  = 7;
  localparam int NIB_MH  = 4;
  localparam int NIB_ML  = 3;
  localparam int NIB_LO  = 0;
  localparam int IRQ5    = 7;
  localparam int IRQ4    = 6;
  localparam int TRIG_HI = 2;
  localparam int TGL1    = 7;
  localparam int TGL0    = 6;
  localparam int RES_HI  = 5;
  localparam int RES_LO  = 4;
  localparam int PDM_B   = 3;
  localparam int CK_HI   = 2;
  localparam int CK_LO   = 0;
  localparam int BG_RD   = 7;
  localparam int BG_DSP  = 6;
  localparam int BG_KEEP_B = 5;
  localparam int BG_AUTO = 4;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== verilog/dgp_bank.sv ====
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bits 7:6 at 0x1B equal 3 turn on the GPIO pulse debounce mono-flop.
// - bits 3:2 at 0x1B pick processor speed fastest, fast, slow, slowest.
// - bit 1 at 0x1B sends pulse output to pin1 when set, pin3 when clear.
// - bit 0 at 0x1B sends pulse output to pin0 when set, pin2 when clear.
// - watchdog is off only while key register holds exactly 0x5A.
// - an enabled watchdog expires between 9 and 12 seconds without a kick.
// - bits 7:4 at 0x1D mask which gpio pins 0..3 start the processor.
// - bits 3:0 at 0x1D enable flip-flop capture of processor inputs 0..3.
// - bits 7 and 6 at 0x1E put active-low interrupt on pin5 and pin4.
// - bits 0, 1, 2 at 0x1E enable starts on capacitance, resistance, timer end.
// - bits 7 and 6 at 0x1F add toggle flip-flops on pulse outputs 1, 0.
// - bits 5:4 at 0x1F pick pulse resolution 10, 12, 14 or 16 bits.
// - bits 7:4 at 0x21 make gpio pins 0..3 inputs when set.
// - bits 3:0 at 0x21 enable pull-ups on gpio pins 0..3 when set.
// - bit 7 at 0x22 requests a bandgap refresh at each readout end.
// - bit 6 at 0x22 lets the processor bandgap trigger request a refresh.
// - bit 5 at 0x22 keeps bandgap always on, else pulsed.
// - bit 4 at 0x22 fires one capacitance conversion after power-on.
module dgp_bank (
  input  wire logic                         REF_CLK,
  input  wire logic                         SYS_RST,
  input  wire logic                         CLK_EN,
  input  wire logic [dgp_pkg::ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire logic                         S_AXI_AWVALID,
  output logic                              S_AXI_AWREADY,
  input  wire logic [31:0]                  S_AXI_WDATA,
  input  wire logic [3:0]                   S_AXI_WSTRB,
  input  wire logic                         S_AXI_WVALID,
  output logic                              S_AXI_WREADY,
  output logic [1:0]                        S_AXI_BRESP,
  output logic                              S_AXI_BVALID,
  input  wire logic                         S_AXI_BREADY,
  input  wire logic [dgp_pkg::ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire logic                         S_AXI_ARVALID,
  output logic                              S_AXI_ARREADY,
  output logic [31:0]                       S_AXI_RDATA,
  output logic [1:0]                        S_AXI_RRESP,
  output logic                              S_AXI_RVALID,
  input  wire logic                         S_AXI_RREADY,
  input  wire logic [3:0]                   GPIO_IN,
  input  wire logic                         PULSE_RAW,
  input  wire logic                         IRQ_N_IN,
  input  wire logic                         PULSE0_IN,
  input  wire logic                         PULSE1_IN,
  input  wire logic                         CAP_DONE,
  input  wire logic                         RES_DONE,
  input  wire logic                         TIMER_DONE,
  input  wire logic                         READOUT_DONE,
  input  wire logic                         PROC_BG_TRIG,
  input  wire logic                         WD_KICK,
  input  wire logic                         POWER_ON_DONE,
  output logic [3:0]                        GPIO_OUT,
  output logic [3:0]                        GPIO_OE,
  output logic [3:0]                        GPIO_PULLUP,
  output logic                              GPIO4_IRQ_N,
  output logic                              GPIO4_IRQ_SEL,
  output logic                              GPIO5_IRQ_N,
  output logic                              GPIO5_IRQ_SEL,
  output logic [1:0]                        PROC_SPEED,
  output logic                              PROC_START,
  output logic [3:0]                        PROC_INPUT_LATCH,
  output logic                              PULSE0_OUT,
  output logic                              PULSE1_OUT,
  output logic [1:0]                        PULSE0_RES,
  output logic [1:0]                        PULSE1_RES,
  output logic                              PULSE0_PDM,
  output logic                              PULSE1_PDM,
  output logic [2:0]                        PULSE0_CLK_SEL,
  output logic [2:0]                        PULSE1_CLK_SEL,
  output logic                              BG_REFRESH,
  output logic                              BG_ALWAYS_ON,
  output logic                              CAP_CONV_START,
  output logic                              WD_EXPIRED
);
  import dgp_pkg::*;

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [7:0] trim_a_reg, speed_reg, wdkey_reg, start_reg;
  logic [7:0] irqtrig_reg, pulse0_reg, pulse1_reg, gpio_reg, bg_reg;

  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    return {{IDX_LSB{1'b0}}, a[ADDR_W-1:IDX_LSB]};
  endfunction

  function automatic logic hit(input logic [7:0] i);
    return (i >= IDX_TRIM_A) && (i <= IDX_STATUS);
  endfunction

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  logic                aw_hold_reg, w_hold_reg;
  logic [ADDR_W-1:0]   awaddr_reg;
  logic [7:0]          wdata_reg;
  logic                wstrb0_reg;
  logic                do_write;
  logic [7:0]          widx;

  assign do_write = aw_hold_reg && w_hold_reg && !S_AXI_BVALID;
  assign widx     = reg_idx(awaddr_reg);

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= RST_ZERO;
      wstrb0_reg    <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_AWREADY <= !aw_hold_reg && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_hold_reg && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold_reg   <= 1'b1;
        awaddr_reg    <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold_reg   <= 1'b1;
        wdata_reg    <= S_AXI_WDATA[7:0];
        wstrb0_reg   <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= hit(widx) && widx != IDX_STATUS ? RESP_OKAY
                                                        : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // host must store mandatory trim values; hardware only holds them
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trim_a_reg  <= RST_TRIM_A;
      speed_reg   <= RST_SPEED;
      wdkey_reg   <= RST_ZERO;
      start_reg   <= RST_ZERO;
      irqtrig_reg <= RST_TRIG;
      pulse0_reg  <= RST_ZERO;
      pulse1_reg  <= RST_ZERO;
      gpio_reg    <= RST_ZERO;
      bg_reg      <= RST_BANDGAP;
    end else if (CLK_EN && do_write && wstrb0_reg) begin
      case (widx)
        IDX_TRIM_A:  trim_a_reg  <= wdata_reg;
        IDX_SPEED:   speed_reg   <= wdata_reg;
        IDX_WDKEY:   wdkey_reg   <= wdata_reg;
        IDX_START:   start_reg   <= wdata_reg;
        IDX_IRQTRIG: irqtrig_reg <= wdata_reg;
        IDX_PULSE0:  pulse0_reg  <= wdata_reg;
        IDX_PULSE1:  pulse1_reg  <= wdata_reg;
        IDX_GPIO:    gpio_reg    <= wdata_reg;
        IDX_BANDGAP: bg_reg      <= wdata_reg;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic [7:0] ridx;

  assign ridx = reg_idx(S_AXI_ARADDR);

  always_comb begin
    case (ridx)
      IDX_TRIM_A:  rd_byte = trim_a_reg;
      IDX_SPEED:   rd_byte = speed_reg;
      IDX_WDKEY:   rd_byte = wdkey_reg;
      IDX_START:   rd_byte = start_reg;
      IDX_IRQTRIG: rd_byte = irqtrig_reg;
      IDX_PULSE0:  rd_byte = pulse0_reg;
      IDX_PULSE1:  rd_byte = pulse1_reg;
      IDX_GPIO:    rd_byte = gpio_reg;
      IDX_BANDGAP: rd_byte = bg_reg;
      IDX_STATUS:  rd_byte = status_byte;
      default:     rd_byte = RST_ZERO;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= '0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (CLK_EN) begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= {24'h000000, rd_byte};
        S_AXI_RRESP   <= hit(ridx) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [11:0] sync1_reg, sync2_reg;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (CLK_EN) begin
      sync1_reg <= {GPIO_IN, PULSE_RAW, IRQ_N_IN, PULSE0_IN, PULSE1_IN,
                    CAP_DONE, RES_DONE, TIMER_DONE, PROC_BG_TRIG};
      sync2_reg <= sync1_reg;
    end
  end

  logic [3:0] gpio_s;
  logic       praw_s, irqn_s, p0_s, p1_s, cap_s, res_s, tim_s, pbg_s;
  assign {gpio_s, praw_s, irqn_s, p0_s, p1_s, cap_s, res_s, tim_s,
          pbg_s} = sync2_reg;

  // ****************************************************************
  // gpio pulse line: debounce and pin swap
  // ****************************************************************
  logic       deb_reg;
  logic [3:0] gpio_out_next;
  logic       pulse_line;

  // debounce holds the line one extra sample; rejects single spikes
  logic praw_d_reg;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      praw_d_reg <= 1'b0;
      deb_reg    <= 1'b0;
    end else if (CLK_EN) begin
      praw_d_reg <= praw_s;
      if (praw_s == praw_d_reg)
        deb_reg <= praw_s;
    end
  end

  assign pulse_line = (speed_reg[MONO_HI:MONO_LO] == MONOFLOP_ON)
                      ? deb_reg : praw_s;

  always_comb begin
    gpio_out_next = '0;
    if (speed_reg[SWAP_LO]) gpio_out_next[0] = pulse_line;
    else                    gpio_out_next[2] = pulse_line;
    if (speed_reg[SWAP_HI]) gpio_out_next[1] = pulse_line;
    else                    gpio_out_next[3] = pulse_line;
  end

  // ****************************************************************
  // processor start, latches, pulse toggles, bandgap
  // ****************************************************************
  logic pin_start, trig_start;
  logic tgl0_reg, tgl1_reg, p0_d_reg, p1_d_reg, auto_done_reg;

  assign pin_start  = |(start_reg[NIB_HI:NIB_MH] & gpio_s);
  assign trig_start = (irqtrig_reg[0] & cap_s)
                    | (irqtrig_reg[1] & res_s)
                    | (irqtrig_reg[TRIG_HI] & tim_s);

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tgl0_reg <= 1'b0;
      tgl1_reg <= 1'b0;
      p0_d_reg <= 1'b0;
      p1_d_reg <= 1'b0;
    end else if (CLK_EN) begin
      p0_d_reg <= p0_s;
      p1_d_reg <= p1_s;
      if (p0_s && !p0_d_reg) tgl0_reg <= !tgl0_reg;
      if (p1_s && !p1_d_reg) tgl1_reg <= !tgl1_reg;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      auto_done_reg  <= 1'b0;
      CAP_CONV_START <= 1'b0;
    end else if (CLK_EN) begin
      CAP_CONV_START <= 1'b0;
      if (POWER_ON_DONE && !auto_done_reg) begin
        auto_done_reg  <= 1'b1;
        CAP_CONV_START <= bg_reg[BG_AUTO];
      end
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(WD_CYCLES - 64'd1);
  logic [WD_W-1:0] wd_cnt_reg;
  logic            wd_off;

  assign wd_off = (wdkey_reg == WD_OFF_KEY);

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wd_cnt_reg <= '0;
      WD_EXPIRED <= 1'b0;
    end else if (CLK_EN) begin
      WD_EXPIRED <= 1'b0;
      if (wd_off || WD_KICK) begin
        wd_cnt_reg <= '0;
      end else if (wd_cnt_reg == WD_LIMIT) begin
        wd_cnt_reg <= '0;
        WD_EXPIRED <= 1'b1;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1;
      end
    end
  end

  assign status_byte = {5'h00, wd_off, auto_done_reg, deb_reg};

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      GPIO_OUT <= '0; GPIO_OE <= '0; GPIO_PULLUP <= '0;
      GPIO4_IRQ_N <= 1'b1; GPIO4_IRQ_SEL <= 1'b0;
      GPIO5_IRQ_N <= 1'b1; GPIO5_IRQ_SEL <= 1'b0;
      PROC_SPEED <= '0; PROC_START <= 1'b0; PROC_INPUT_LATCH <= '0;
      PULSE0_OUT <= 1'b0; PULSE1_OUT <= 1'b0;
      PULSE0_RES <= '0; PULSE1_RES <= '0;
      PULSE0_PDM <= 1'b0; PULSE1_PDM <= 1'b0;
      PULSE0_CLK_SEL <= '0; PULSE1_CLK_SEL <= '0;
      BG_REFRESH <= 1'b0; BG_ALWAYS_ON <= 1'b0;
    end else if (CLK_EN) begin
      GPIO_OUT    <= gpio_out_next;
      GPIO_OE     <= ~gpio_reg[NIB_HI:NIB_MH];
      GPIO_PULLUP <= gpio_reg[NIB_ML:NIB_LO];
      GPIO4_IRQ_SEL <= irqtrig_reg[IRQ4];
      GPIO5_IRQ_SEL <= irqtrig_reg[IRQ5];
      GPIO4_IRQ_N <= irqtrig_reg[IRQ4] ? irqn_s : 1'b1;
      GPIO5_IRQ_N <= irqtrig_reg[IRQ5] ? irqn_s : 1'b1;
      PROC_SPEED  <= speed_reg[SPD_HI:SPD_LO];
      PROC_START  <= pin_start | trig_start;
      PROC_INPUT_LATCH <= start_reg[NIB_ML:NIB_LO];
      PULSE0_OUT  <= pulse0_reg[TGL0] ? tgl0_reg : p0_s;
      PULSE1_OUT  <= pulse0_reg[TGL1] ? tgl1_reg : p1_s;
      PULSE0_RES  <= pulse0_reg[RES_HI:RES_LO];
      PULSE1_RES  <= pulse1_reg[RES_HI:RES_LO];
      PULSE0_PDM  <= pulse0_reg[PDM_B];
      PULSE1_PDM  <= pulse1_reg[PDM_B];
      PULSE0_CLK_SEL <= pulse0_reg[CK_HI:CK_LO];
      PULSE1_CLK_SEL <= pulse1_reg[CK_HI:CK_LO];
      BG_REFRESH  <= (bg_reg[BG_RD] & READOUT_DONE)
                   | (bg_reg[BG_DSP] & pbg_s);
      BG_ALWAYS_ON <= bg_reg[BG_KEEP_B];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_wd_key_off: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    wdkey_reg == WD_OFF_KEY |=> !WD_EXPIRED)
    else $error("watchdog fired while key says off");
  a_wd_min_time: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $rose(WD_EXPIRED) |-> $past(wd_cnt_reg) == WD_LIMIT)
    else $error("watchdog fired early");
  a_swap_lo: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && speed_reg[SWAP_LO] |=> !GPIO_OUT[2])
    else $error("pulse on pin2 while swapped");
  a_swap_hi: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && speed_reg[SWAP_HI] |=> !GPIO_OUT[3])
    else $error("pulse on pin3 while swapped");
  a_dir_pins: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN |=> GPIO_OE == ~$past(gpio_reg[NIB_HI:NIB_MH]))
    else $error("direction mismatch");
  a_pullup: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN |=> GPIO_PULLUP == $past(gpio_reg[NIB_ML:NIB_LO]))
    else $error("pull-up mismatch");
  a_irq_route: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && !irqtrig_reg[IRQ5] |=> GPIO5_IRQ_N)
    else $error("interrupt on pin5 while not routed");
  a_bg_refresh: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN && !bg_reg[BG_RD] && !bg_reg[BG_DSP] |=> !BG_REFRESH)
    else $error("bandgap refresh while both sources off");
  a_auto_once: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CAP_CONV_START |=> !CAP_CONV_START[*8])
    else $error("power-on conversion fired twice");
  a_speed_out: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CLK_EN |=> PROC_SPEED == $past(speed_reg[SPD_HI:SPD_LO]))
    else $error("speed mismatch");
endmodule
`default_nettype wire

// ==== tb/dgp_bank_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dgp_bank_bench;
  import dgp_pkg::*;
  // ********************************
  // design ports, named as the design's
  // ********************************
  logic REF_CLK, SYS_RST, CLK_EN, S_AXI_AWVALID, S_AXI_AWREADY;
  logic S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB, GPIO_IN, GPIO_OUT, GPIO_OE, GPIO_PULLUP;
  logic [3:0] PROC_INPUT_LATCH;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, PROC_SPEED, PULSE0_RES, PULSE1_RES;
  logic [2:0] PULSE0_CLK_SEL, PULSE1_CLK_SEL;
  logic PULSE_RAW, IRQ_N_IN, PULSE0_IN, PULSE1_IN, CAP_DONE, RES_DONE;
  logic TIMER_DONE, READOUT_DONE, PROC_BG_TRIG, WD_KICK, POWER_ON_DONE;
  logic GPIO4_IRQ_N, GPIO4_IRQ_SEL, GPIO5_IRQ_N, GPIO5_IRQ_SEL, PROC_START;
  logic PULSE0_OUT, PULSE1_OUT, PULSE0_PDM, PULSE1_PDM, BG_REFRESH;
  logic BG_ALWAYS_ON, CAP_CONV_START, WD_EXPIRED;
  int errors;
  int cmp_count;
  logic [7:0] rst_tab [9] = '{8'h52, 8'h08, 8'h00, 8'h00, 8'h02,
                              8'h00, 8'h00, 8'h00, 8'h07};
  logic [7:0] keys [4] = '{8'h5A, 8'h5B, 8'h00, 8'hDA};

  dgp_bank u_dut (.*);

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  // ********************************
  // compare and bus tasks
  // ********************************
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask
  // valid and payload held until the edge that sees ready high
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] rs;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= idx << IDX_LSB;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_WSTRB <= 4'h1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge REF_CLK);
      aw = S_AXI_AWVALID && S_AXI_AWREADY;
      w = S_AXI_WVALID && S_AXI_WREADY;
      b = S_AXI_BVALID;
      rs = S_AXI_BRESP;
      @(posedge REF_CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    chk_resp(rs, er);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input logic [1:0] er);
    logic ar, r;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= idx << IDX_LSB;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge REF_CLK);
      ar = S_AXI_ARVALID && S_AXI_ARREADY;
      r = S_AXI_RVALID;
      d = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      @(posedge REF_CLK);
      if (ar) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
    chk_val(d, exp);
    chk_resp(rs, er);
  endtask

  // ********************************
  // watchdog: whole run needs a few hundred cycles
  // ********************************
  initial begin
    tick(20000);
    errors++;
    finish_test();
  end

  // ********************************
  // tests
  // ********************************
  initial begin
    errors = 0;
    cmp_count = 0;
    {SYS_RST, CLK_EN, IRQ_N_IN} = 3'b111;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'b000;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_WSTRB} = 6'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    {GPIO_IN, PULSE_RAW, PULSE0_IN, PULSE1_IN, CAP_DONE, RES_DONE} = '0;
    {TIMER_DONE, READOUT_DONE, PROC_BG_TRIG, WD_KICK, POWER_ON_DONE} = '0;
    tick(4);
    SYS_RST <= 1'b0;
    tick(2);
    for (int i = 0; i < 9; i++) begin
      rd(IDX_TRIM_A + 8'(i), {24'h0, rst_tab[i]}, RESP_OKAY);
    end
    for (int i = 0; i < 9; i++) begin
      wr(IDX_TRIM_A + 8'(i), 8'hA5 ^ 8'(i), RESP_OKAY);
      rd(IDX_TRIM_A + 8'(i), {24'h0, 8'hA5 ^ 8'(i)}, RESP_OKAY);
    end
    wr(8'h00, 8'hFF, RESP_SLVERR);
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(IDX_STATUS, 8'hFF, RESP_SLVERR);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_SPEED, 8'(s << 2), RESP_OKAY);
      tick(2);
      chk_val(32'(PROC_SPEED), 32'(s));
    end
    // pins set as outputs so the routed pulse shows on them
    wr(IDX_GPIO, 8'h00, RESP_OKAY);
    PULSE_RAW <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(IDX_SPEED, 8'(s), RESP_OKAY);
      tick(8);
      chk_val(32'(GPIO_OUT), {28'h0, ~s[1], ~s[0], s[1], s[0]});
    end
    wr(IDX_SPEED, 8'hC0, RESP_OKAY);
    tick(8);
    chk_val(32'(GPIO_OUT), 32'hC);
    PULSE_RAW <= 1'b0;
    tick(8);
    chk_val(32'(GPIO_OUT), 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_WDKEY, keys[k], RESP_OKAY);
      rd(IDX_STATUS, (keys[k] == WD_OFF_KEY) ? 32'h4 : 32'h0, RESP_OKAY);
    end
    wr(IDX_IRQTRIG, 8'h00, RESP_OKAY);
    wr(IDX_START, 8'h5A, RESP_OKAY);
    GPIO_IN <= 4'b0100;
    tick(5);
    chk_val(32'(PROC_INPUT_LATCH), 32'hA);
    chk_val(32'(PROC_START), 32'h1);
    GPIO_IN <= 4'b1010;
    tick(5);
    chk_val(32'(PROC_START), 32'h0);
    GPIO_IN <= 4'b0000;
    for (int i = 0; i < 3; i++) begin
      wr(IDX_IRQTRIG, 8'(1 << i), RESP_OKAY);
      {TIMER_DONE, RES_DONE, CAP_DONE} <= 3'(1 << i);
      tick(5);
      chk_val(32'(PROC_START), 32'h1);
      {TIMER_DONE, RES_DONE, CAP_DONE} <= ~3'(1 << i);
      tick(5);
      chk_val(32'(PROC_START), 32'h0);
    end
    {TIMER_DONE, RES_DONE, CAP_DONE} <= 3'b000;
    wr(IDX_IRQTRIG, 8'hC0, RESP_OKAY);
    IRQ_N_IN <= 1'b0;
    tick(5);
    chk_val(32'({GPIO5_IRQ_SEL, GPIO4_IRQ_SEL, GPIO5_IRQ_N, GPIO4_IRQ_N}), 32'hC);
    wr(IDX_IRQTRIG, 8'h40, RESP_OKAY);
    tick(2);
    chk_val(32'({GPIO5_IRQ_SEL, GPIO4_IRQ_SEL, GPIO5_IRQ_N, GPIO4_IRQ_N}), 32'h6);
    wr(IDX_PULSE0, 8'h3D, RESP_OKAY);
    wr(IDX_PULSE1, 8'h2E, RESP_OKAY);
    tick(2);
    chk_val(32'({PULSE0_RES, PULSE0_PDM, PULSE0_CLK_SEL}), 32'h3D);
    chk_val(32'({PULSE1_RES, PULSE1_PDM, PULSE1_CLK_SEL}), 32'h2E);
    // toggled output keeps its level after the input falls again
    wr(IDX_PULSE0, 8'hC0, RESP_OKAY);
    {PULSE1_IN, PULSE0_IN} <= 2'b11;
    tick(5);
    {PULSE1_IN, PULSE0_IN} <= 2'b00;
    tick(5);
    chk_val(32'({PULSE1_OUT, PULSE0_OUT}), 32'h3);
    wr(IDX_GPIO, 8'h5C, RESP_OKAY);
    tick(2);
    chk_val(32'({GPIO_OE, GPIO_PULLUP}), 32'hAC);
    wr(IDX_BANDGAP, 8'h27, RESP_OKAY);
    tick(2);
    chk_val(32'(BG_ALWAYS_ON), 32'h1);
    wr(IDX_BANDGAP, 8'h87, RESP_OKAY);
    READOUT_DONE <= 1'b1;
    tick(2);
    chk_val(32'(BG_REFRESH), 32'h1);
    READOUT_DONE <= 1'b0;
    tick(2);
    chk_val(32'(BG_REFRESH), 32'h0);
    wr(IDX_BANDGAP, 8'h17, RESP_OKAY);
    POWER_ON_DONE <= 1'b1;
    tick(2);
    chk_val(32'(CAP_CONV_START), 32'h1);
    tick(1);
    rd(IDX_STATUS, 32'h2, RESP_OKAY);
    finish_test();
  end
endmodule
`default_nettype wire
